// *** rtl/panel_defs.vh ***
`ifndef PANEL_DEFS_VH
`define PANEL_DEFS_VH
// Panel modes
`define MODE_SETTING 3'h0
`define MODE_MONITOR 3'h1
`define MODE_TRACE 3'h2
`define MODE_STATUS 3'h3
`define MODE_SWVER 3'h4
// Setting sub-states
`define SET_NUMBER 1'b0
`define SET_VALUE 1'b1
// Operation-mode selection values
`define OPSEL_SWVER 8'h06
// Monitor numbers
`define MON_SPEED 3'h0
`define MON_TORQUE 3'h2
`define MON_UPULSE 3'h3
`define MON_ANGLE 3'h4
`define MON_STATUS 3'h5
`define MON_POSERR 3'h6
`define MON_LAST 3'h6
// Alarm codes (8-bit display codes)
`define ALM_ABS_DATA 8'h00
`define ALM_PRM_BREAK 8'h02
`define ALM_PRM_SET 8'h04
`define ALM_OVERCUR 8'h10
`define ALM_OVERFLOW 8'h31
`define ALM_OVERVOLT 8'h40
`define ALM_OVERSPEED 8'h51
`define ALM_OVL_PEAK 8'h71
`define ALM_OVL_CONT 8'h72
`define ALM_ABS_ENC 8'h80
`define ALM_ABS_BACKUP 8'h81
`define ALM_ABS_CSUM 8'h82
`define ALM_ABS_BATT 8'h83
`define ALM_ABS_ADATA 8'h84
`define ALM_ABS_OSPD 8'h85
`define ALM_OVERRUN 8'hC1
`define ALM_PHASE 8'hC2
`define ALM_AB_LOSS 8'hC3
`define ALM_C_LOSS 8'hC4
`define ALM_PWR_LOSS 8'hF3
`define ALM_MARKER 8'h99
`define ALM_NONE 8'hFF
// Overspeed threshold in percent
`define OVERSPEED_PCT 8'd110
`define PCT_FULL 8'd100
`endif

// *** rtl/servo_panel_monitor_alarm_log.v ***
// Functional notes
// - Selection constant 06 plus set key enters software version mode.
// - Enter returns to constant number; set then goes setting to monitor.
// - Up/down step monitor number; enter toggles display and selection.
// - Monitor numbers select speed, torque, pulses, angle, status, position error.
// - Set key in monitor mode goes to alarm traceback.
// - Set key in traceback mode goes to status display.
// - Segments 1,2,4,5: alarm, brake, current limit, positioning done.
// - Segments 6..9: mode switch, forward limit, reverse limit, motor on.
// - Segments 10..15 show encoder phases inverted; U,V,W incremental only.
// - Segments 16..19: servo on, P control, forward and reverse prohibit.
// - History holds at most ten past alarm entries.
// - Power-on or alarm reset logs a marker entry into history.
// - Up/down scroll sequence number; higher number is older entry.
// - Operator transmission errors shown but never logged.
// - Overspeed alarm when speed exceeds 110 percent of maximum.
// - Power loss alarm when power returns within holding time.
// - Alarms 81..85 raised only with 12-bit absolute encoder; 00 and 80 with any absolute encoder.
// - Distinct alarms for phase error, A/B loss and C loss.
// - Distinct alarms for overrun, parameters, overcurrent, overflow, voltage, overload.
`timescale 1ns/1ps
`include "panel_defs.vh"
module servo_panel_monitor_alarm_log #(
   parameter DW = 16,
   parameter DEPTH = 10
) (
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Keys from the operator unit, one-cycle pulses on sys_clk
   input wire set_key,
   input wire enter_key,
   input wire up_key,
   input wire down_key,
   input wire [7:0] operation_mode_select_constant,
   // Monitored quantities
   input wire [DW-1:0] feedback_speed,
   input wire [DW-1:0] torque_ref_pct,
   input wire [DW-1:0] u_edge_pulses,
   input wire [DW-1:0] elec_angle,
   input wire [DW-1:0] position_error,
   input wire [DW-1:0] max_speed,
   // Status sources (same clock)
   input wire servo_alarm_flag,
   input wire dynamic_brake_active,
   input wire current_limiting_flag,
   input wire positioning_done_flag,
   input wire mode_switch_active,
   input wire fwd_current_limit_input,
   input wire rev_current_limit_input,
   input wire motor_energised,
   input wire servo_on_flag,
   input wire proportional_ctrl_input,
   input wire fwd_rotation_prohibit,
   input wire rev_rotation_prohibit,
   // Encoder phase pins, asynchronous
   input wire enc_phase_a_in,
   input wire enc_phase_b_in,
   input wire enc_phase_c_in,
   input wire enc_phase_u_in,
   input wire enc_phase_v_in,
   input wire enc_phase_w_in,
   input wire incremental_encoder,
   input wire abs12_encoder,
   // Alarm detector conditions, one-cycle pulses
   input wire absolute_encoder,
   input wire det_abs_data,
   input wire det_prm_break,
   input wire det_prm_set,
   input wire det_overcurrent,
   input wire det_overflow,
   input wire det_overvolt,
   input wire det_ovl_peak,
   input wire det_ovl_cont,
   input wire det_abs_enc,
   input wire det_abs_backup,
   input wire det_abs_csum,
   input wire det_abs_batt,
   input wire det_abs_adata,
   input wire det_abs_ospd,
   input wire det_overrun,
   input wire det_phase,
   input wire det_ab_loss,
   input wire det_c_loss,
   input wire power_restored_in_hold,
   input wire alarm_reset,
   input wire op_tx_err1,
   input wire op_tx_err2,
   // Panel outputs
   output reg [2:0] panel_mode_ff,
   output reg [2:0] monitor_num_ff,
   output reg monitor_showing_ff,
   output reg [DW-1:0] monitor_value_ff,
   output reg [19:0] status_bits_ff,
   output reg [3:0] trace_seq_ff,
   output reg [7:0] trace_code_ff,
   output reg [7:0] alarm_code_ff,
   output reg alarm_active_ff,
   output reg [1:0] op_err_disp_ff
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   reg [5:0] enc_meta_ff;
   reg [5:0] enc_sync_ff;
   // Two stages; only the second is read
   always @(posedge sys_clk) begin
      enc_meta_ff <= {enc_phase_w_in, enc_phase_v_in, enc_phase_u_in, enc_phase_c_in, enc_phase_b_in, enc_phase_a_in};
      enc_sync_ff <= enc_meta_ff;
   end

   // ****************************************
   // Panel mode machine
   // ****************************************
   reg set_sub_ff;
   // Set key cycles setting, monitor, traceback, status; status has no exit of
   // its own, so set returns to setting there
   always @(posedge sys_clk) begin
      if (rst) begin
         panel_mode_ff <= `MODE_MONITOR;
         set_sub_ff <= `SET_NUMBER;
         monitor_num_ff <= `MON_SPEED;
         monitor_showing_ff <= 1'b0;
         trace_seq_ff <= 4'h0;
      end else begin
         case (panel_mode_ff)
            `MODE_SETTING: begin
               if (enter_key)
                  set_sub_ff <= ~set_sub_ff;
               else if (set_key && set_sub_ff == `SET_VALUE &&
                        operation_mode_select_constant == `OPSEL_SWVER)
                  panel_mode_ff <= `MODE_SWVER;
               else if (set_key && set_sub_ff == `SET_NUMBER)
                  panel_mode_ff <= `MODE_MONITOR;
            end
            `MODE_SWVER: begin
               if (enter_key) begin
                  panel_mode_ff <= `MODE_SETTING;
                  set_sub_ff <= `SET_NUMBER;
               end
            end
            `MODE_MONITOR: begin
               if (set_key) begin
                  panel_mode_ff <= `MODE_TRACE;
                  monitor_showing_ff <= 1'b0;
                  trace_seq_ff <= 4'h0;
               end else if (enter_key)
                  monitor_showing_ff <= ~monitor_showing_ff;
               else if (!monitor_showing_ff && up_key)
                  monitor_num_ff <= next_mon(monitor_num_ff, 1'b1);
               else if (!monitor_showing_ff && down_key)
                  monitor_num_ff <= next_mon(monitor_num_ff, 1'b0);
            end
            `MODE_TRACE: begin
               if (set_key)
                  panel_mode_ff <= `MODE_STATUS;
               else if (up_key && trace_seq_ff != DEPTH - 1)
                  trace_seq_ff <= trace_seq_ff + 4'h1;
               else if (down_key && trace_seq_ff != 4'h0)
                  trace_seq_ff <= trace_seq_ff - 4'h1;
            end
            `MODE_STATUS: begin
               if (set_key) begin
                  panel_mode_ff <= `MODE_SETTING;
                  set_sub_ff <= `SET_NUMBER;
               end
            end
            default: panel_mode_ff <= `MODE_MONITOR;
         endcase
      end
   end

   // Step over the unused monitor number 01, wrapping at the ends
   function [2:0] next_mon;
      input [2:0] cur;
      input up;
      begin
         if (up)
            next_mon = (cur == `MON_LAST) ? `MON_SPEED : (cur == `MON_SPEED) ? `MON_TORQUE : cur + 3'h1;
         else
            next_mon = (cur == `MON_SPEED) ? `MON_LAST : (cur == `MON_TORQUE) ? `MON_SPEED : cur - 3'h1;
      end
   endfunction

   // ****************************************
   // Status bit display and monitor value
   // ****************************************
   reg [19:0] nxt_status_bits;
   // Index n holds display position n+1
   always @* begin
      nxt_status_bits = 20'h00000;
      nxt_status_bits[0] = servo_alarm_flag;
      nxt_status_bits[1] = dynamic_brake_active;
      nxt_status_bits[2] = 1'b0;
      nxt_status_bits[3] = current_limiting_flag;
      nxt_status_bits[4] = positioning_done_flag;
      nxt_status_bits[5] = mode_switch_active;
      nxt_status_bits[6] = fwd_current_limit_input;
      nxt_status_bits[7] = rev_current_limit_input;
      nxt_status_bits[8] = motor_energised;
      nxt_status_bits[11:9] = ~enc_sync_ff[2:0];
      nxt_status_bits[14:12] = incremental_encoder ? ~enc_sync_ff[5:3] : 3'h0;
      nxt_status_bits[15] = servo_on_flag;
      nxt_status_bits[16] = proportional_ctrl_input;
      nxt_status_bits[17] = fwd_rotation_prohibit;
      nxt_status_bits[18] = rev_rotation_prohibit;
      nxt_status_bits[19] = 1'b0;
   end

   reg [DW-1:0] nxt_monitor_value;
   // Blank while selecting a number, so a stale value never shows
   always @* begin
      nxt_monitor_value = {DW{1'b0}};
      if (monitor_showing_ff) begin
         case (monitor_num_ff)
            `MON_SPEED: nxt_monitor_value = feedback_speed;
            `MON_TORQUE: nxt_monitor_value = torque_ref_pct;
            `MON_UPULSE: nxt_monitor_value = u_edge_pulses;
            `MON_ANGLE: nxt_monitor_value = elec_angle;
            `MON_STATUS: nxt_monitor_value = {{(DW-1){1'b0}}, 1'b0} | nxt_status_bits[DW-1:0];
            `MON_POSERR: nxt_monitor_value = position_error;
            default: nxt_monitor_value = {DW{1'b0}};
         endcase
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         status_bits_ff <= 20'h00000;
         monitor_value_ff <= {DW{1'b0}};
      end else begin
         status_bits_ff <= nxt_status_bits;
         monitor_value_ff <= nxt_monitor_value;
      end
   end

   // ****************************************
   // Alarm detection and priority
   // ****************************************
   wire [DW+7:0] speed_x100 = feedback_speed * `PCT_FULL;
   wire [DW+7:0] limit_x110 = max_speed * `OVERSPEED_PCT;
   wire overspeed = speed_x100 > limit_x110;
   reg [7:0] nxt_alarm;
   // Lowest listed code wins when several detectors fire together
   always @* begin
      nxt_alarm = `ALM_NONE;
      if (det_abs_data && absolute_encoder) nxt_alarm = `ALM_ABS_DATA;
      else if (det_prm_break) nxt_alarm = `ALM_PRM_BREAK;
      else if (det_prm_set) nxt_alarm = `ALM_PRM_SET;
      else if (det_overcurrent) nxt_alarm = `ALM_OVERCUR;
      else if (det_overflow) nxt_alarm = `ALM_OVERFLOW;
      else if (det_overvolt) nxt_alarm = `ALM_OVERVOLT;
      else if (overspeed) nxt_alarm = `ALM_OVERSPEED;
      else if (det_ovl_peak) nxt_alarm = `ALM_OVL_PEAK;
      else if (det_ovl_cont) nxt_alarm = `ALM_OVL_CONT;
      else if (det_abs_enc && absolute_encoder) nxt_alarm = `ALM_ABS_ENC;
      else if (det_abs_backup && abs12_encoder) nxt_alarm = `ALM_ABS_BACKUP;
      else if (det_abs_csum && abs12_encoder) nxt_alarm = `ALM_ABS_CSUM;
      else if (det_abs_batt && abs12_encoder) nxt_alarm = `ALM_ABS_BATT;
      else if (det_abs_adata && abs12_encoder) nxt_alarm = `ALM_ABS_ADATA;
      else if (det_abs_ospd && abs12_encoder) nxt_alarm = `ALM_ABS_OSPD;
      else if (det_overrun) nxt_alarm = `ALM_OVERRUN;
      else if (det_phase && incremental_encoder) nxt_alarm = `ALM_PHASE;
      else if (det_ab_loss) nxt_alarm = `ALM_AB_LOSS;
      else if (det_c_loss) nxt_alarm = `ALM_C_LOSS;
      else if (power_restored_in_hold) nxt_alarm = `ALM_PWR_LOSS;
   end

   // ****************************************
   // Alarm history
   // ****************************************
   reg [7:0] hist_ff [0:DEPTH-1];
   reg boot_ff;
   // A new alarm is logged only when none is latched; reset logs the marker
   wire new_alarm = (nxt_alarm != `ALM_NONE) && !alarm_active_ff;
   wire log_marker = boot_ff || alarm_reset;
   wire log_en = log_marker || new_alarm;
   wire [7:0] log_code = log_marker ? `ALM_MARKER : nxt_alarm;

   // Slot 0 is newest; a shift drops slot DEPTH-1, the oldest
   always @(posedge sys_clk) begin
      if (rst)
         hist_ff[0] <= `ALM_NONE;
      else if (log_en)
         hist_ff[0] <= log_code;
   end
   genvar gi;
   generate
      for (gi = 1; gi < DEPTH; gi = gi + 1) begin : g_hist
         always @(posedge sys_clk) begin
            if (rst)
               hist_ff[gi] <= `ALM_NONE;
            else if (log_en)
               hist_ff[gi] <= hist_ff[gi-1];
         end
      end
   endgenerate

   // Latched alarm, marker logging after reset, operator errors
   always @(posedge sys_clk) begin
      if (rst) begin
         boot_ff <= 1'b1;
         alarm_active_ff <= 1'b0;
         alarm_code_ff <= `ALM_NONE;
         op_err_disp_ff <= 2'h0;
         trace_code_ff <= `ALM_NONE;
      end else begin
         boot_ff <= 1'b0;
         if (alarm_reset) begin
            alarm_active_ff <= 1'b0;
            alarm_code_ff <= `ALM_NONE;
         end else if (new_alarm) begin
            alarm_active_ff <= 1'b1;
            alarm_code_ff <= nxt_alarm;
         end
         // Shown only, never fed into the history
         op_err_disp_ff <= {op_tx_err2, op_tx_err1};
         trace_code_ff <= hist_ff[trace_seq_ff];
      end
   end

endmodule

// *** sim/panel_chk.sv ***
`timescale 1ns/1ps
`include "panel_defs.vh"
// ****
// Panel checker
// ****
module panel_chk #(
   parameter DW = 16
) (
   // Clock, reset and keys
   input wire sys_clk,
   input wire rst,
   input wire set_key,
   input wire enter_key,
   input wire up_key,
   input wire down_key,
   // Sources
   input wire [DW-1:0] feedback_speed,
   input wire [DW-1:0] max_speed,
   input wire servo_alarm_flag,
   input wire dynamic_brake_active,
   input wire alarm_reset,
   input wire op_tx_err1,
   input wire op_tx_err2,
   // Panel outputs
   input wire [2:0] panel_mode_ff,
   input wire [2:0] monitor_num_ff,
   input wire monitor_showing_ff,
   input wire [19:0] status_bits_ff,
   input wire [3:0] trace_seq_ff,
   input wire [1:0] op_err_disp_ff,
   input wire alarm_active_ff
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Mode steps on the set key
   property p_mon_set; panel_mode_ff == `MODE_MONITOR && set_key |=> panel_mode_ff == `MODE_TRACE; endproperty
   a_mon_set: assert property (p_mon_set) else $error("monitor set key missed traceback");
   property p_trc_set; panel_mode_ff == `MODE_TRACE && set_key |=> panel_mode_ff == `MODE_STATUS; endproperty
   a_trc_set: assert property (p_trc_set) else $error("traceback set key missed status");
   // Monitor number selection and display toggle
   property p_num_up; panel_mode_ff == `MODE_MONITOR && !monitor_showing_ff && up_key && !set_key && !enter_key
      && monitor_num_ff == 3'h0 |=> monitor_num_ff == 3'h2; endproperty
   a_num_up: assert property (p_num_up) else $error("monitor number did not skip to 2");
   property p_num_hold; panel_mode_ff == `MODE_MONITOR && monitor_showing_ff && up_key && !set_key && !enter_key
      |=> $stable(monitor_num_ff); endproperty
   a_num_hold: assert property (p_num_hold) else $error("number moved while showing");
   property p_show; panel_mode_ff == `MODE_MONITOR && enter_key && !set_key
      |=> monitor_showing_ff != $past(monitor_showing_ff); endproperty
   a_show: assert property (p_show) else $error("enter did not toggle display");
   // Status positions; two unused ones stay dark
   property p_stat; 1'b1 |=> status_bits_ff[1:0] == $past({dynamic_brake_active, servo_alarm_flag}); endproperty
   a_stat: assert property (p_stat) else $error("alarm or brake position wrong");
   property p_unused; status_bits_ff[2] == 1'b0 && status_bits_ff[19] == 1'b0; endproperty
   a_unused: assert property (p_unused) else $error("unused position lit");
   // Traceback scrolling moves one step and never past ten entries
   property p_seq; panel_mode_ff == `MODE_TRACE && (up_key ^ down_key) && !set_key && trace_seq_ff inside {[1:8]}
      |=> trace_seq_ff == $past(trace_seq_ff) + 4'h1 || trace_seq_ff == $past(trace_seq_ff) - 4'h1; endproperty
   a_seq: assert property (p_seq) else $error("sequence step wrong");
   property p_seq_max; trace_seq_ff <= 4'h9; endproperty
   a_seq_max: assert property (p_seq_max) else $error("sequence beyond nine");
   // Alarm latch, reset and operator errors
   property p_ospd; !alarm_active_ff && !alarm_reset && !$past(rst) && feedback_speed * 32'd100 > max_speed * 32'd110
      |=> alarm_active_ff; endproperty
   a_ospd: assert property (p_ospd) else $error("overspeed not raised");
   property p_ares; alarm_reset |=> !alarm_active_ff; endproperty
   a_ares: assert property (p_ares) else $error("alarm reset did not clear");
   property p_operr; op_tx_err1 && op_tx_err2 |-> ##[1:3] op_err_disp_ff == 2'h3; endproperty
   a_operr: assert property (p_operr) else $error("operator errors not shown");
endmodule

// *** sim/op_unit.sv ***
`timescale 1ns/1ps
// ****
// Operator keypad model
// ****
module op_unit (
   // Clock
   input wire sys_clk,
   // Key pulses toward the panel
   output reg set_key,
   output reg enter_key,
   output reg up_key,
   output reg down_key
);
   // Keys idle low
   initial begin
      {set_key, enter_key, up_key, down_key} = 4'h0;
   end
   // One key per press, one clock wide: 0 set, 1 enter, 2 up, 3 down
   task press(input [1:0] k);
      begin
         @(posedge sys_clk);
         #1;
         {set_key, enter_key, up_key, down_key} = 4'h8 >> k;
         @(posedge sys_clk);
         #1;
         {set_key, enter_key, up_key, down_key} = 4'h0;
      end
   endtask
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ps
`include "panel_defs.vh"
`define CHK(g, e) chk(g, e);
// ****
// Panel testbench
// ****
module tb;
   logic sys_clk, rst, inc, a12, absn, ares;
   logic [7:0] opsel;
   logic [15:0] spd, trq, mx, upc, ang, perr;
   logic [15:0] mv [6];
   logic [11:0] st;
   logic [5:0] ph;
   logic [18:0] alm;
   logic [1:0] terr;
   logic [7:0] codes [20];
   wire sk, ek, uk, dnk, show, act;
   wire [2:0] mode, mnum;
   wire [15:0] mval;
   wire [19:0] sbits;
   wire [3:0] tseq;
   wire [7:0] tcode, acode;
   wire [1:0] oerr;
   int mismatches, checked, i;
   op_unit u_op (.sys_clk(sys_clk), .set_key(sk), .enter_key(ek), .up_key(uk), .down_key(dnk));
   servo_panel_monitor_alarm_log u_dut (.sys_clk(sys_clk), .rst(rst), .set_key(sk), .enter_key(ek),
      .up_key(uk), .down_key(dnk), .operation_mode_select_constant(opsel), .feedback_speed(spd),
      .torque_ref_pct(trq), .u_edge_pulses(upc), .elec_angle(ang), .position_error(perr),
      .max_speed(mx), .servo_alarm_flag(st[0]), .dynamic_brake_active(st[1]), .current_limiting_flag(st[2]),
      .positioning_done_flag(st[3]), .mode_switch_active(st[4]), .fwd_current_limit_input(st[5]),
      .rev_current_limit_input(st[6]), .motor_energised(st[7]), .servo_on_flag(st[8]),
      .proportional_ctrl_input(st[9]), .fwd_rotation_prohibit(st[10]), .rev_rotation_prohibit(st[11]),
      .enc_phase_a_in(ph[0]), .enc_phase_b_in(ph[1]), .enc_phase_c_in(ph[2]), .enc_phase_u_in(ph[3]),
      .enc_phase_v_in(ph[4]), .enc_phase_w_in(ph[5]), .incremental_encoder(inc), .abs12_encoder(a12),
      .absolute_encoder(absn), .det_abs_data(alm[0]), .det_prm_break(alm[1]), .det_prm_set(alm[2]),
      .det_overcurrent(alm[3]), .det_overflow(alm[4]), .det_overvolt(alm[5]), .det_ovl_peak(alm[6]),
      .det_ovl_cont(alm[7]), .det_abs_enc(alm[8]), .det_abs_backup(alm[9]), .det_abs_csum(alm[10]),
      .det_abs_batt(alm[11]), .det_abs_adata(alm[12]), .det_abs_ospd(alm[13]), .det_overrun(alm[14]),
      .det_phase(alm[15]), .det_ab_loss(alm[16]), .det_c_loss(alm[17]), .power_restored_in_hold(alm[18]),
      .alarm_reset(ares), .op_tx_err1(terr[0]), .op_tx_err2(terr[1]), .panel_mode_ff(mode),
      .monitor_num_ff(mnum), .monitor_showing_ff(show), .monitor_value_ff(mval), .status_bits_ff(sbits),
      .trace_seq_ff(tseq), .trace_code_ff(tcode), .alarm_code_ff(acode), .alarm_active_ff(act),
      .op_err_disp_ff(oerr));
   // Clock at 10 MHz
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // Compare and count
   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         checked++;
         if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task tally_and_finish;
      begin
         $display("checked=%0d mismatches=%0d", checked, mismatches);
         if (mismatches == 0 && checked > 0) begin
            $display("No errors found");
         end else begin
            $display("Errors were found");
         end
         $finish;
      end
   endtask
   // Wait n edges, then settle past the edge
   task tick(input int n);
      begin
         repeat (n) @(posedge sys_clk);
         #1;
      end
   endtask
   // Hang guard, far beyond the few hundred cycles the run needs
   initial begin
      #3000000;
      mismatches++;
      tally_and_finish;
   end
   // Main sequence
   initial begin
      codes = '{`ALM_ABS_DATA, `ALM_PRM_BREAK, `ALM_PRM_SET, `ALM_OVERCUR, `ALM_OVERFLOW, `ALM_OVERVOLT,
         `ALM_OVL_PEAK, `ALM_OVL_CONT, `ALM_ABS_ENC, `ALM_ABS_BACKUP, `ALM_ABS_CSUM, `ALM_ABS_BATT,
         `ALM_ABS_ADATA, `ALM_ABS_OSPD, `ALM_OVERRUN, `ALM_PHASE, `ALM_AB_LOSS, `ALM_C_LOSS, `ALM_PWR_LOSS,
         `ALM_OVERSPEED};
      // Alarm reset starts low, or every cycle would log a marker
      {rst, inc, a12, absn, ares, opsel, spd, trq, mx, st, ph, alm, terr} = {5'h1E, 8'h00, 16'h0, 16'h1234,
         16'h0064, 12'h0, 6'h0, 19'h0, 2'h0};
      {upc, ang, perr} = 48'h0;
      tick(20);
      rst = 1'b0;
      tick(1);
      `CHK(mode, `MODE_MONITOR)
      `CHK(acode, `ALM_NONE)
      // Monitor number walk, skipping 01 and wrapping from 06 back to 00
      for (i = 0; i < 6; i++) begin
         u_op.press(2);
         `CHK(mnum, (i == 5) ? 0 : i + 2)
      end
      // Each number shows its own quantity; up refused while showing; hiding blanks
      mv = '{16'h0042, 16'h1234, 16'h5A5A, 16'h0F0F, 16'h7E00, 16'hBEEF}; // Status: encoder inputs low
      {spd, trq, upc, ang, perr} = {mv[0], mv[1], mv[2], mv[3], mv[5]};
      for (i = 0; i < 6; i++) begin
         u_op.press(1);
         tick(2);
         `CHK(mval, mv[i])
         u_op.press(2);
         `CHK(mnum, i ? i + 1 : 0)
         u_op.press(1);
         tick(2);
         `CHK(mval, 0)
         u_op.press(2);
      end
      // Three status patterns; encoder positions inverted, U/V/W dark unless incremental
      for (i = 0; i < 3; i++) begin
         {inc, st, ph} = i ? {i == 1, 12'hA5A, 6'h2A} : {1'b1, 12'hFFF, 6'h15};
         tick(4);
         `CHK(sbits[8:0], {st[7:2], 1'b0, st[1:0]})
         `CHK(sbits[19:9], {1'b0, st[11:8], ~ph[5:3] & {3{inc}}, ~ph[2:0]})
      end
      inc = 1'b1;
      // Every alarm kind but overspeed, each followed by an alarm reset
      for (i = 0; i < 19; i++) begin
         alm = 19'h1 << i;
         tick(1);
         alm = 19'h0;
         `CHK(acode, codes[i])
         ares = 1'b1;
         tick(1);
         ares = 1'b0;
         tick(1);
      end
      // Without a 12-bit encoder a backup fault stays silent
      a12 = 1'b0;
      alm = 19'h200;
      tick(1);
      alm = 19'h0;
      tick(2);
      `CHK(act, 0)
      // Without an absolute encoder its data and encoder faults stay silent
      absn = 1'b0;
      alm = 19'h101;
      tick(1);
      alm = 19'h0;
      tick(2);
      `CHK(act, 0)
      absn = 1'b1;
      terr = 2'h3;
      tick(4);
      `CHK(oerr, 3)
      `CHK(act, 0)
      terr = 2'h0;
      // Overspeed boundary: exactly 110 percent is still fine
      {mx, spd} = {16'd200, 16'd220};
      tick(3);
      `CHK(act, 0)
      spd = 16'd221;
      tick(2);
      `CHK(acode, `ALM_OVERSPEED)
      spd = 16'd0;
      ares = 1'b1;
      tick(1);
      ares = 1'b0;
      // History walk; up steps to older entries and stops at the oldest
      u_op.press(0);
      `CHK(mode, `MODE_TRACE)
      for (i = 0; i < 10; i++) begin
         tick(2);
         `CHK(tseq, i)
         `CHK(tcode, (i % 2) ? codes[19 - i / 2] : `ALM_MARKER)
         u_op.press(2);
      end
      `CHK(tseq, 9)
      // Status, setting, version mode and back to monitor
      u_op.press(0);
      `CHK(mode, `MODE_STATUS)
      u_op.press(0);
      opsel = `OPSEL_SWVER;
      u_op.press(1);
      u_op.press(0);
      `CHK(mode, `MODE_SWVER)
      u_op.press(1);
      `CHK(mode, `MODE_SETTING)
      u_op.press(0);
      `CHK(mode, `MODE_MONITOR)
      tally_and_finish;
   end
endmodule
bind servo_panel_monitor_alarm_log panel_chk #(.DW(DW)) u_chk (.sys_clk(sys_clk), .rst(rst), .set_key(set_key),
   .enter_key(enter_key), .up_key(up_key), .down_key(down_key), .feedback_speed(feedback_speed),
   .max_speed(max_speed), .servo_alarm_flag(servo_alarm_flag), .dynamic_brake_active(dynamic_brake_active),
   .alarm_reset(alarm_reset), .op_tx_err1(op_tx_err1), .op_tx_err2(op_tx_err2), .panel_mode_ff(panel_mode_ff),
   .monitor_num_ff(monitor_num_ff), .monitor_showing_ff(monitor_showing_ff), .status_bits_ff(status_bits_ff),
   .trace_seq_ff(trace_seq_ff), .op_err_disp_ff(op_err_disp_ff), .alarm_active_ff(alarm_active_ff));
